//--- include/cantw_pkg.sv
// Shared constants for the CAN transceiver mode and wake-up control block
package cantw_pkg;

  // Interface modes
  typedef enum logic [1:0] {
    MODE_TXRX,
    MODE_RXONLY,
    MODE_SLEEP
  } cantw_mode_e;

  // Slew rate codes, fastest is the default
  localparam logic [1:0] SLEW_FAST   = 2'h0;
  localparam logic [1:0] SLEW_MEDIUM = 2'h1;
  localparam logic [1:0] SLEW_SLOW   = 2'h2;

  // Timing in nanoseconds at a 125 MHz clock
  localparam int CLK_PERIOD_NS    = 8;
  localparam int PULSE_MIN_NS     = 500;
  localparam int WINDOW_NS        = 120000;
  localparam int SINGLE_PULSE_NS  = 2000;
  // Least times round up, the window (a longest time) rounds down
  localparam int PULSE_MIN_CYC    =
    (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WINDOW_CYC       = WINDOW_NS / CLK_PERIOD_NS;
  localparam int SINGLE_PULSE_CYC =
    (SINGLE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int PATTERN_PULSES   = 3;
  localparam int CNT_W            = 14;

endpackage

//--- core/cantw_mode_wake.sv
// CAN transceiver mode control, bus drive mapping and bus wake-up detection
// Functional notes
// [R1] Tx/rx: driver, receiver on; bus follows transmit; receive shows bus.
// [R2] Receive-only: driver off, receiver reports bus, transmit input ignored.
// [R3] Driver enables only in normal mode once transmit input is recessive.
// [R4] Driver on: transmit high gives recessive, low gives dominant drive.
// [R5] Receive output high when bus recessive, low when bus dominant; the code holds it high in sleep mode whatever the bus.
// [R6] Three selectable slew rates; fastest is the default.
// [R7] Controller keeps bit rate at or above 40 kBaud.
// [R8] Sleep: drivers off, lines terminated to ground, split pin released.
// [R9] Bus wake sets a sticky flag, pulses interrupt, wakes low-power device.
// [R10] Returning from sleep to normal restores lines to recessive.
// [R11] Bus wake-up detection in sleep is enabled by a control setting.
// [R12] Pattern wake needs three dominant pulses, each longer than 500 ns.
// [R13] The three pattern pulses must fall within a 120 us window.
// [R14] Single-pulse select set: wake after one dominant pulse of 2.0 us.
// [R15] Split bias active in tx/rx and receive-only modes.
// [R16] Permanent recessive receive failure sets a flag, forces receive-only.
// [R17] Pattern pulse counter restarts when the window expires early.
`timescale 1ns/1ps

module cantw_mode_wake #(
  parameter int WINDOW_CYC = cantw_pkg::WINDOW_CYC
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       txData,
  output logic            rxData,
  input  wire logic [1:0] modeRequest,
  input  wire logic       slewWrite,
  input  wire logic [1:0] slewSelect,
  input  wire logic       wakeEnable,
  input  wire logic       single_pulse_wake_select,
  input  wire logic       wakeFlagClear,
  input  wire logic       rxFailClear,
  input  wire logic       lowPower,
  output logic [1:0]      slewRate,
  output logic            wakeFlag,
  output logic            wakePulse,
  output logic            wakeRequest,
  output logic            rxHighFail,
  output logic [1:0]      modeActive,
  input  wire logic       busDominant,
  input  wire logic       wakeRxDominant,
  input  wire logic       rxPinSense,
  output logic            driveDominant,
  output logic            driverEnable,
  output logic            receiverEnable,
  output logic            splitEnable,
  output logic            termToGround
);

  // ---------------------------------------------------------------
  // Reset release and input synchronisers
  // ---------------------------------------------------------------
  logic       rstMeta;
  logic       rstSync;
  logic [4:0] syncA;
  logic [4:0] syncB;
  logic       txS;
  logic       busS;
  logic       wakeS;
  logic       senseS;
  logic       wakeEnS;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      {rstSync, rstMeta} <= 2'h0;
    else
      {rstSync, rstMeta} <= {rstMeta, 1'b1};
  end

  // Pins and analog comparators are asynchronous to clk
  always_ff @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
      {syncB, syncA} <= {5'h01, 5'h01};
    else
      {syncB, syncA} <= {syncA, wakeEnable, rxPinSense, wakeRxDominant,
                         busDominant, txData};
  end

  assign {wakeEnS, senseS, wakeS, busS, txS} = syncB;

  // ---------------------------------------------------------------
  // Mode control
  // ---------------------------------------------------------------
  cantw_pkg::cantw_mode_e mode;
  cantw_pkg::cantw_mode_e reqMode;
  logic                   wakeDet;

  always_comb
  begin
    unique case (modeRequest)
      2'h0:    reqMode = cantw_pkg::MODE_TXRX;
      2'h1:    reqMode = cantw_pkg::MODE_RXONLY;
      default: reqMode = cantw_pkg::MODE_SLEEP;
    endcase
  end

  always_ff @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
      mode <= cantw_pkg::MODE_SLEEP;
    else if (wakeDet && mode == cantw_pkg::MODE_SLEEP)
      mode <= rxHighFail ? cantw_pkg::MODE_RXONLY : cantw_pkg::MODE_TXRX; // R9
    else if (rxHighFail && reqMode == cantw_pkg::MODE_TXRX)
      mode <= cantw_pkg::MODE_RXONLY; // R16
    else
      mode <= reqMode;
  end

  assign modeActive = mode;

  // ---------------------------------------------------------------
  // Driver arming and bus drive
  // ---------------------------------------------------------------
  // Arming waits for recessive transmit so a stuck-low input
  // cannot clamp the bus on entry into normal mode
  logic armed;

  always_ff @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
      armed <= 1'b0;
    else if (mode != cantw_pkg::MODE_TXRX)
      armed <= 1'b0; // R2 R8
    else if (txS)
      armed <= 1'b1; // R3
  end

  always_ff @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
      {driverEnable, driveDominant} <= 2'h0;
    else
    begin
      driverEnable  <= armed; // R1 R3
      driveDominant <= armed && !txS; // R4 R10
    end
  end

  always_ff @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      receiverEnable <= 1'b0;
      splitEnable    <= 1'b0;
      termToGround   <= 1'b1;
      rxData         <= 1'b1;
    end
    else
    begin
      receiverEnable <= mode != cantw_pkg::MODE_SLEEP; // R1 R2
      splitEnable    <= mode != cantw_pkg::MODE_SLEEP; // R15 R8
      termToGround   <= mode == cantw_pkg::MODE_SLEEP; // R8
      rxData         <= (mode == cantw_pkg::MODE_SLEEP) || !busS; // R5
    end
  end

  // ---------------------------------------------------------------
  // Slew rate
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
      slewRate <= cantw_pkg::SLEW_FAST; // R6
    else if (slewWrite && slewSelect != 2'h3)
      slewRate <= slewSelect; // R6
  end

  // ---------------------------------------------------------------
  // Receive permanent recessive detection
  // ---------------------------------------------------------------
  // Checked at each dominant-to-recessive edge of the bus outside sleep mode:
  // the pin should still read low just before, as it follows the bus
  logic busPrev;
  logic sensePrev;

  always_ff @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      busPrev    <= 1'b0;
      sensePrev  <= 1'b1;
      rxHighFail <= 1'b0;
    end
    else
    begin
      busPrev   <= busS;
      sensePrev <= senseS;
      if (mode != cantw_pkg::MODE_SLEEP && busPrev && !busS && sensePrev)
        rxHighFail <= 1'b1; // R16
      else if (rxFailClear && !txS)
        rxHighFail <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Bus wake-up detection
  // ---------------------------------------------------------------
  logic [cantw_pkg::CNT_W-1:0] pulseCnt;
  logic [cantw_pkg::CNT_W-1:0] winCnt;
  logic [1:0]                  pulseNum;
  logic                        winOpen;
  logic                        wakeArm;
  logic                        pulseValid;
  logic                        pulseEnd;

  assign wakeArm    = mode == cantw_pkg::MODE_SLEEP && wakeEnS; // R11
  assign pulseValid = pulseCnt >= cantw_pkg::CNT_W'(cantw_pkg::PULSE_MIN_CYC);
  assign pulseEnd   = !wakeS && pulseCnt != '0;

  always_ff @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
      pulseCnt <= '0;
    else if (!wakeArm || !wakeS)
      pulseCnt <= '0;
    else if (pulseCnt != '1)
      pulseCnt <= pulseCnt + 1'b1;
  end

  always_ff @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      pulseNum <= 2'h0;
      winCnt   <= '0;
      winOpen  <= 1'b0;
      wakeDet  <= 1'b0;
    end
    else
    begin
      wakeDet <= 1'b0;
      if (!wakeArm)
      begin
        pulseNum <= 2'h0;
        winOpen  <= 1'b0;
        winCnt   <= '0;
      end
      else if (single_pulse_wake_select)
      begin
        if (pulseCnt == cantw_pkg::CNT_W'(cantw_pkg::SINGLE_PULSE_CYC))
          wakeDet <= 1'b1; // R14
      end
      else
      begin
        if (winOpen)
          winCnt <= winCnt + 1'b1;
        if (winOpen && winCnt >= cantw_pkg::CNT_W'(WINDOW_CYC - 1))
        begin
          pulseNum <= 2'h0; // R13 R17
          winOpen  <= 1'b0;
          winCnt   <= '0;
        end
        else if (pulseEnd && pulseValid) // R12
        begin
          if (!winOpen)
          begin
            winOpen <= 1'b1;
            winCnt  <= pulseCnt;
          end
          if (pulseNum == 2'(cantw_pkg::PATTERN_PULSES - 1))
          begin
            wakeDet  <= 1'b1; // R12 R13
            pulseNum <= 2'h0;
            winOpen  <= 1'b0;
          end
          else
            pulseNum <= pulseNum + 1'b1;
        end
      end
    end
  end

  // Sticky flag: a new wake wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      wakeFlag    <= 1'b0;
      wakePulse   <= 1'b0;
      wakeRequest <= 1'b0;
    end
    else
    begin
      wakePulse   <= wakeDet; // R9
      wakeRequest <= wakeDet && lowPower; // R9
      if (wakeDet)
        wakeFlag <= 1'b1; // R9
      else if (wakeFlagClear)
        wakeFlag <= 1'b0;
    end
  end

endmodule

//--- verif/cantw_props.sv
// Assertion checker for the mode, drive and wake-up block
`timescale 1ns/1ps
module cantw_props (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       txData,
  input wire logic       rxData,
  input wire logic       slewWrite,
  input wire logic [1:0] slewSelect,
  input wire logic [1:0] slewRate,
  input wire logic       wakeFlag,
  input wire logic       wakePulse,
  input wire logic       rxHighFail,
  input wire logic [1:0] modeActive,
  input wire logic       busDominant,
  input wire logic       driveDominant,
  input wire logic       driverEnable,
  input wire logic       splitEnable,
  input wire logic       termToGround
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Five samples cover the two-flop sync plus output register
  sequence s_txLow;
    (driverEnable && !txData) [*5];
  endsequence
  sequence s_txHigh;
    (driverEnable && txData) [*5];
  endsequence
  property p_sleepOff;
    (modeActive == 2'h2) [*3] |-> !driverEnable && termToGround && !splitEnable;
  endproperty
  property p_split;
    (modeActive != 2'h2) [*3] |-> splitEnable && !termToGround;
  endproperty
  property p_drvMode;
    driverEnable |-> $past(modeActive, 2) == 2'h0;
  endproperty
  property p_arm;
    $rose(driverEnable) |-> $past(txData, 4);
  endproperty
  property p_txDom;
    s_txLow |-> driveDominant;
  endproperty
  property p_txRec;
    s_txHigh |-> !driveDominant;
  endproperty
  property p_rxDom;
    (busDominant && modeActive != 2'h2) [*5] |-> !rxData;
  endproperty
  property p_rxRec;
    (!busDominant) [*4] |-> rxData;
  endproperty
  property p_wake;
    wakePulse |-> wakeFlag ##1 !wakePulse;
  endproperty
  property p_slew;
    slewWrite |=> slewRate == ($past(slewSelect) == 2'h3 ?
                               $past(slewRate) : $past(slewSelect));
  endproperty
  property p_fail;
    rxHighFail |=> modeActive != 2'h0;
  endproperty
  a_sleepOff: assert property (p_sleepOff)
    else $error("sleep outputs wrong");
  a_split: assert property (p_split)
    else $error("split bias off while awake");
  a_drvMode: assert property (p_drvMode)
    else $error("driver on outside tx/rx mode");
  a_arm: assert property (p_arm)
    else $error("driver enabled without recessive transmit");
  a_txDom: assert property (p_txDom)
    else $error("low transmit not dominant");
  a_txRec: assert property (p_txRec)
    else $error("high transmit not recessive");
  a_rxDom: assert property (p_rxDom)
    else $error("receive high on dominant bus");
  a_rxRec: assert property (p_rxRec)
    else $error("receive low on recessive bus");
  a_wake: assert property (p_wake)
    else $error("wake pulse malformed");
  a_slew: assert property (p_slew)
    else $error("slew rate load wrong");
  a_fail: assert property (p_fail)
    else $error("tx/rx mode kept after receive failure");
endmodule

//--- verif/cantw_bus_model.sv
// Bus and receive pin model facing the analog side of the block
`timescale 1ns/1ps
module cantw_bus_model (
  input  wire logic driveDominant,
  input  wire logic driverEnable,
  input  wire logic rxData,
  input  wire logic remoteDom,
  input  wire logic rxStuck,
  output logic      busDominant,
  output logic      wakeRxDominant,
  output logic      rxPinSense
);
  // Wired bus: any dominant driver wins over recessive
  assign busDominant    = (driverEnable & driveDominant) | remoteDom;
  assign wakeRxDominant = remoteDom;
  // Stuck input models a receive pin shorted high
  assign rxPinSense     = rxData | rxStuck;
endmodule

//--- verif/cantw_mode_wake_tb.sv
// Self-checking bench for the mode, drive and wake-up block
`timescale 1ns/1ps
module cantw_mode_wake_tb;
  localparam int WIN = 400;
  logic        clk, reset_n, txData, rxData, slewWrite, wakeEnable;
  logic        single_pulse_wake_select, wakeFlagClear, rxFailClear;
  logic        lowPower, wakeFlag, wakePulse, wakeRequest, rxHighFail;
  logic        busDominant, wakeRxDominant, rxPinSense, driveDominant;
  logic        driverEnable, receiverEnable, splitEnable, termToGround;
  logic        remoteDom, rxStuck;
  logic [1:0]  modeRequest, slewSelect, slewRate, modeActive, curSlew;
  logic [31:0] lfsr;
  int          errorCnt, checksDone, cyc, wakeCnt, reqCnt;

  cantw_mode_wake #(.WINDOW_CYC(WIN)) u_dut (.clk, .reset_n, .txData,
    .rxData, .modeRequest, .slewWrite, .slewSelect, .wakeEnable,
    .single_pulse_wake_select, .wakeFlagClear, .rxFailClear, .lowPower,
    .slewRate, .wakeFlag, .wakePulse, .wakeRequest, .rxHighFail,
    .modeActive, .busDominant, .wakeRxDominant, .rxPinSense,
    .driveDominant, .driverEnable, .receiverEnable, .splitEnable,
    .termToGround);
  cantw_bus_model u_bus (.driveDominant, .driverEnable, .rxData,
    .remoteDom, .rxStuck, .busDominant, .wakeRxDominant, .rxPinSense);

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [1:0] slewExp(input logic [1:0] c, s);
    return (s == 2'h3) ? c : s;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chkBit(input string w, input logic e, g);
    checksDone++;
    if (g !== e)
    begin
      errorCnt++;
      $display("MISMATCH %s expected %b seen %b", w, e, g);
    end
  endtask
  task automatic chkField(input string w, input logic [1:0] e, g);
    chkBit(w, e[1], g[1]);
    chkBit(w, e[0], g[0]);
  endtask
  task automatic pulse(input int hi, lo);
    remoteDom <= 1'b1;
    tick(hi);
    remoteDom <= 1'b0;
    tick(lo);
  endtask
  task automatic expWake(input logic n);
    tick(10);
    chkBit("wakeFlag", n, wakeFlag);
    chkBit("wakeCount", n, wakeCnt == 1);
    wakeFlagClear <= 1'b1;
    tick(1);
    wakeFlagClear <= 1'b0;
    wakeCnt = 0;
    tick(500);
  endtask
  task automatic results;
    if (errorCnt == 0 && checksDone > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Wake counting and hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (wakePulse === 1'b1) wakeCnt <= wakeCnt + 1;
    if (wakeRequest === 1'b1) reqCnt <= reqCnt + 1;
    if (cyc == 30000)
    begin
      errorCnt++;
      results();
    end
  end

  initial
  begin
    {reset_n, slewWrite, wakeEnable, single_pulse_wake_select} = '0;
    {wakeFlagClear, rxFailClear, lowPower, remoteDom, rxStuck} = '0;
    {slewSelect, curSlew, modeRequest} = {4'h0, 2'h2};
    {errorCnt, checksDone, cyc, wakeCnt, reqCnt} = '0;
    txData = 1'b1;
    lfsr = 32'h6ffb_c544;
    tick(12);
    reset_n <= 1'b1;
    tick(6);
    chkField("slewRate", 2'h0, slewRate);
    chkBit("term", 1'b1, termToGround);
    for (int i = 0; i < 4; i++)
    begin
      slewSelect <= 2'(i);
      slewWrite <= 1'b1;
      tick(1);
      slewWrite <= 1'b0;
      curSlew = slewExp(curSlew, 2'(i));
      tick(2);
      chkField("slewRate", curSlew, slewRate);
    end
    modeRequest <= 2'h0;
    tick(8);
    chkBit("drvEn", 1'b1, driverEnable);
    chkBit("split", 1'b1, splitEnable);
    chkBit("rxEn", 1'b1, receiverEnable);
    repeat (40)
    begin
      lfsr = nxt(lfsr);
      txData <= lfsr[0];
      tick(10);
      chkBit("drive", ~lfsr[0], driveDominant);
      chkBit("rxData", lfsr[0], rxData);
    end
    chkBit("rxFail", 1'b0, rxHighFail);
    modeRequest <= 2'h1;
    txData <= 1'b0;
    tick(10);
    chkBit("drvEn", 1'b0, driverEnable);
    chkBit("rxEn", 1'b1, receiverEnable);
    chkBit("rxData", 1'b1, rxData);
    modeRequest <= 2'h0;
    txData <= 1'b1;
    tick(10);
    rxStuck <= 1'b1;
    txData <= 1'b0;
    tick(10);
    txData <= 1'b1;
    tick(10);
    chkBit("rxFail", 1'b1, rxHighFail);
    chkField("mode", 2'h1, modeActive);
    rxStuck <= 1'b0;
    txData <= 1'b0;
    rxFailClear <= 1'b1;
    tick(6);
    {rxFailClear, txData} <= 2'b01;
    tick(4);
    chkBit("rxFail", 1'b0, rxHighFail);
    {lowPower, wakeEnable, modeRequest} <= 4'b1110;
    tick(8);
    chkBit("split", 1'b0, splitEnable);
    repeat (3) pulse(80, 20);
    chkField("wakeReq", 2'h1, 2'(reqCnt));
    expWake(1'b1);
    repeat (3) pulse(50, 20);
    expWake(1'b0);
    pulse(80, 450);
    repeat (2) pulse(80, 20);
    chkBit("early", 1'b0, wakeFlag);
    pulse(80, 20);
    expWake(1'b1);
    single_pulse_wake_select <= 1'b1;
    pulse(240, 30);
    expWake(1'b0);
    pulse(260, 30);
    expWake(1'b1);
    {wakeEnable, single_pulse_wake_select} <= 2'b00;
    tick(4);
    repeat (3) pulse(80, 20);
    expWake(1'b0);
    chkField("wakeReq", 2'h3, 2'(reqCnt));
    modeRequest <= 2'h0;
    tick(8);
    chkBit("drive", 1'b0, driveDominant);
    chkBit("term", 1'b0, termToGround);
    results();
  end
endmodule

bind cantw_mode_wake cantw_props u_props (.clk, .reset_n, .txData, .rxData,
  .slewWrite, .slewSelect, .slewRate, .wakeFlag, .wakePulse, .rxHighFail,
  .modeActive, .busDominant, .driveDominant, .driverEnable, .splitEnable,
  .termToGround);
